// [verilog/sac_map.svh]
// Register offsets, field positions, reset values and timing codes of the converter control.
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
`define SAC_ADDR_W 16
`define SAC_MODE_ADDR 16'hff80
`define SAC_CHAN_ADDR 16'hff81
`define SAC_RESULT_ADDR 16'hff82
`define SAC_MODE_RESET 8'h00
`define SAC_CHAN_RESET 8'h00
`define SAC_BIT_REF_ON 0
`define SAC_BIT_EDGE_LO 1
`define SAC_BIT_EDGE_HI 2
`define SAC_BIT_TIME_LO 3
`define SAC_BIT_TIME_HI 5
`define SAC_BIT_TRG_MODE 6
`define SAC_BIT_ENABLE 7
`define SAC_CHAN_MASK 8'h07
`define SAC_EDGE_FALL 1
`define SAC_EDGE_RISE 2
`define SAC_CYC_000 9'h090
`define SAC_CYC_001 9'h078
`define SAC_CYC_010 9'h060
`define SAC_CYC_100 9'h120
`define SAC_CYC_101 9'h0f0
`define SAC_CYC_110 9'h0c0
`define SAC_TRIALS 9
`endif

// [verilog/sac_pkg.sv]
// Types shared by the converter control files.
package sac_pkg;
	typedef logic [7:0] sac_byte_type;
	typedef logic [2:0] sac_chan_type;
	typedef enum logic [1:0] {SAC_IDLE, SAC_SAMPLE, SAC_TRIAL} sac_state_type;
endpackage

// [verilog/sac_result_store.sv]
// Result register: holds the last finished conversion and feeds the read path.
`timescale 1ns/10ps
module sac_result_store
(
	// Clock.
	input  wire logic            clk_in,
	// Load strobe and data.
	input  wire logic            load_in,
	input  wire sac_pkg::sac_byte_type data_in,
	// Stored value.
	output sac_pkg::sac_byte_type      value_out
);
	import sac_pkg::*;
	// No reset: the stored value is undefined after reset.
	sac_byte_type value;

	// Capture the approximation value when a conversion finishes.
	always_ff @(posedge clk_in)
	begin
		if (load_in)
			value <= data_in;
	end

	assign value_out = value;
endmodule

// [verilog/sac_control.sv]
// Successive-approximation converter control: registers, sequencer and result path.
`timescale 1ns/10ps
`include "sac_map.svh"

// Operation
// [R1] Eight channels, one converted at a time, 8-bit.
// [R2] Approximation resolves MSB first from comparator.
// [R3] Result register loaded at every conversion end.
// [R4] Hardware start: one conversion per trigger edge.
// [R5] Software start: conversions repeat back to back.
// [R6] Enable bit starts and stops conversion.
// [R7] Trigger mode: 0 software, 1 hardware.
// [R8] Time field selects 96 to 288 clocks; code runs 90 to 288, each length cut down to a multiple of 9.
// [R9] Edge field: none, falling, rising, both.
// [R10] Reference runs when on bit or enable.
// [R11] First result undefined if reference was off.
// [R12] Software waits for reference settle first.
// [R13] Software picks conversion time long enough.
// [R14] Software stops conversion before changing time.
// [R15] Mode register bit or byte writable, resets 00.
// [R16] Channel register low three bits, upper zero.
// [R17] Unselected analog pins stay digital inputs.
// [R18] Software avoids port reads during conversion.
// [R19] Result register readable as one byte.
// [R20] Trial each bit from 7 down to 0.
// [R21] Register write mid-conversion aborts and restarts; in hardware mode code waits for the next edge.
// [R22] Writing enable clear stops without result.
// [R23] Edge field sits at mode bits 1 and 2.
// [R24] Length split evenly over sample and trials.
// [R25] Done pulse coincides with result load.
module sac_control
(
	// Clock and reset.
	input  wire logic                   clk_in,
	input  wire logic                   rst_b_in,
	// Register port: byte data with per-bit write mask.
	input  wire logic [`SAC_ADDR_W-1:0] addr_in,
	input  wire logic                   wr_in,
	input  wire sac_pkg::sac_byte_type  wr_mask_in,
	input  wire sac_pkg::sac_byte_type  wr_data_in,
	input  wire logic                   rd_in,
	output sac_pkg::sac_byte_type       rd_data_out,
	// Analog side.
	input  wire logic                   comparator_in,
	input  wire logic                   ext_trigger_pin_in,
	output logic [7:0]                  analog_select_out,
	output sac_pkg::sac_byte_type       trial_value_out,
	output logic                        reference_enable_out,
	output logic                        conversion_busy_out,
	// Event.
	output logic                        conversion_done_irq_out
);
	import sac_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Registers and decode.
	sac_byte_type  converter_mode_reg;   // Mode register.
	sac_byte_type  channel_select_reg;   // Channel register, upper bits zero.
	sac_byte_type  approximation_reg;    // Trial and resolved bits.
	sac_byte_type  bit_ptr;              // One-hot pointer to the bit on trial.
	sac_state_type state;                // Sequencer state.
	logic [8:0]    step_cnt;             // Cycles left in the current step.
	logic          trig_s1, trig_s2, trig_d; // Trigger synchroniser and history.
	logic [2:0]    trig_fill;            // Edges ignored until the history holds real pin levels.
	logic          ref_was_on;           // Reference was running before enable.
	logic          result_undefined;     // First result after a cold start.
	sac_byte_type  result_value;         // Output of the result store.
	sac_byte_type  rd_data;              // Registered read data.
	logic          done_pulse;           // Completion pulse.

	// A full byte write replaces every bit; a single-bit write masks one.
	function automatic sac_byte_type merge(input sac_byte_type old_v,
		input sac_byte_type mask, input sac_byte_type data);
		merge = (old_v & ~mask) | (data & mask);
	endfunction

	// Conversion length in clocks for a time code; prohibited codes use the longest.
	function automatic logic [8:0] conv_cycles(input logic [2:0] code);
		case (code)
			3'b000:  conv_cycles = `SAC_CYC_000;
			3'b001:  conv_cycles = `SAC_CYC_001;
			3'b010:  conv_cycles = `SAC_CYC_010;
			3'b100:  conv_cycles = `SAC_CYC_100;
			3'b101:  conv_cycles = `SAC_CYC_101;
			3'b110:  conv_cycles = `SAC_CYC_110;
			default: conv_cycles = `SAC_CYC_100;
		endcase
	endfunction

	wire        mode_wr   = wr_in && (addr_in == `SAC_MODE_ADDR);
	wire        chan_wr   = wr_in && (addr_in == `SAC_CHAN_ADDR);
	wire        enable    = converter_mode_reg[`SAC_BIT_ENABLE];     // [R6]
	wire        hw_mode   = converter_mode_reg[`SAC_BIT_TRG_MODE];   // [R7]
	wire [1:0]  edge_sel  = converter_mode_reg[`SAC_BIT_EDGE_HI:`SAC_BIT_EDGE_LO]; // [R23]
	wire [2:0]  time_code = converter_mode_reg[`SAC_BIT_TIME_HI:`SAC_BIT_TIME_LO];
	// Each of sampling and eight trials gets an equal share of the length.
	wire [8:0]  step_len  = conv_cycles(time_code) / 9'(`SAC_TRIALS); // [R8] [R24]
	wire        fall_seen = trig_fill[2] && trig_d && !trig_s2;
	wire        rise_seen = trig_fill[2] && !trig_d && trig_s2;
	// Valid edge as selected by the edge field.
	wire        edge_hit  = (edge_sel[0] && fall_seen) || (edge_sel[1] && rise_seen); // [R9]
	wire        reg_write = mode_wr || chan_wr;
	// Software mode runs whenever enabled; hardware mode waits for an edge.
	wire        start_now = enable && (hw_mode ? edge_hit : 1'b1); // [R4] [R5]
	wire        step_end  = (step_cnt == 9'd1);
	wire        last_bit  = bit_ptr[0];
	// Comparator high keeps the trial bit, low clears it.
	wire [7:0]  resolved  = comparator_in ? approximation_reg : (approximation_reg & ~bit_ptr); // [R2]
	wire        finish    = (state == SAC_TRIAL) && step_end && last_bit && !reg_write;

	////////////////////////////////////////////////////////////////////////////
	// Register writes.
	// Mode and channel registers accept masked bit or byte writes.
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			converter_mode_reg <= `SAC_MODE_RESET;  // [R15]
			channel_select_reg <= `SAC_CHAN_RESET;  // [R16]
		end
		else
		begin
			if (mode_wr)
				converter_mode_reg <= merge(converter_mode_reg, wr_mask_in, wr_data_in); // [R15]
			if (chan_wr)
				channel_select_reg <= merge(channel_select_reg, wr_mask_in, wr_data_in)
					& `SAC_CHAN_MASK; // [R16]
		end
	end

	// Trigger pin comes from outside and passes two flops before use.
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			trig_s1 <= 1'b0;
			trig_s2 <= 1'b0;
			trig_d  <= 1'b0;
			trig_fill <= 3'b000;
		end
		else
		begin
			trig_s1 <= ext_trigger_pin_in;
			trig_s2 <= trig_s1;
			trig_d  <= trig_s2;
			trig_fill <= {trig_fill[1:0], 1'b1};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer.
	// A register write restarts: software mode at once, hardware mode at the next edge.
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			state             <= SAC_IDLE;
			step_cnt          <= 9'd0;
			bit_ptr           <= 8'h00;
			approximation_reg <= 8'h00;
			done_pulse        <= 1'b0;
		end
		else
		begin
			done_pulse <= finish; // [R25]
			if (reg_write)
			begin
				// Abort without result; re-entry happens from idle.
				state <= SAC_IDLE; // [R21] [R22]
			end
			else
			begin
				unique case (state)
					SAC_IDLE:
					begin
						if (start_now)
						begin
							state    <= SAC_SAMPLE;
							step_cnt <= step_len;
						end
					end
					SAC_SAMPLE:
					begin
						if (!enable)
							state <= SAC_IDLE;
						else if (step_end)
						begin
							// Begin with bit 7 set for trial.
							state             <= SAC_TRIAL;
							bit_ptr           <= 8'h80; // [R20]
							approximation_reg <= 8'h80;
							step_cnt          <= step_len;
						end
						else
							step_cnt <= step_cnt - 9'd1;
					end
					SAC_TRIAL:
					begin
						if (!enable)
							state <= SAC_IDLE; // [R6]
						else if (step_end)
						begin
							// Resolve this bit and set the next one for trial.
							approximation_reg <= resolved | (bit_ptr >> 1); // [R2] [R20]
							bit_ptr           <= bit_ptr >> 1;
							step_cnt          <= step_len;
							if (last_bit)
							begin
								// Hardware mode stops; software mode repeats.
								if (hw_mode)
									state <= SAC_IDLE; // [R4]
								else
									state <= SAC_SAMPLE; // [R5]
							end
						end
						else
							step_cnt <= step_cnt - 9'd1;
					end
				endcase
			end
		end
	end

	// Track whether the reference was already running when conversion enabled.
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			ref_was_on       <= 1'b0;
			result_undefined <= 1'b0;
		end
		else
		begin
			ref_was_on <= converter_mode_reg[`SAC_BIT_REF_ON] || enable;
			if (enable && !ref_was_on)
				result_undefined <= 1'b1; // [R11]
			else if (finish)
				result_undefined <= 1'b0;
		end
	end

	// Result register; the result of a cold start is left for software to discard.
	sac_result_store u_store
	(
		.clk_in    (clk_in),
		.load_in   (finish),
		.data_in   (resolved),
		.value_out (result_value)
	); // [R3]

	////////////////////////////////////////////////////////////////////////////
	// Read path and outputs.
	wire [7:0] rd_mux = (addr_in == `SAC_MODE_ADDR)   ? converter_mode_reg :
	                    (addr_in == `SAC_CHAN_ADDR)   ? channel_select_reg :
	                    (addr_in == `SAC_RESULT_ADDR) ? result_value : 8'h00; // [R19]

	// Read data is registered one cycle after the request.
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			rd_data <= 8'h00;
		else if (rd_in)
			rd_data <= rd_mux;
	end

	// Decoded channel select and reference enable come from flops.
	logic [7:0] sel_q;
	logic       ref_q;
	logic       busy_q;
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			sel_q  <= 8'h00;
			ref_q  <= 1'b0;
			busy_q <= 1'b0;
		end
		else
		begin
			// Only the chosen pin is routed to the converter. [R1] [R17]
			sel_q  <= 8'h01 << channel_select_reg[2:0];
			ref_q  <= converter_mode_reg[`SAC_BIT_REF_ON] || enable; // [R10]
			busy_q <= (state != SAC_IDLE) && !reg_write;
		end
	end

	assign rd_data_out             = rd_data;
	assign analog_select_out       = sel_q;
	assign reference_enable_out    = ref_q;
	assign conversion_busy_out     = busy_q;
	assign trial_value_out         = approximation_reg;
	assign conversion_done_irq_out = done_pulse;

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	sequence s_trial_start;
		state == SAC_SAMPLE && step_end && enable && !reg_write;
	endsequence
	property p_msb_first;
		@(posedge clk_in) disable iff (!rst_b_in)
		s_trial_start |=> (bit_ptr == 8'h80 && approximation_reg == 8'h80);
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("First trial not bit 7."); // [R20]
	property p_done_one_cycle;
		@(posedge clk_in) disable iff (!rst_b_in) done_pulse |=> !done_pulse;
	endproperty
	a_done_one_cycle: assert property (p_done_one_cycle) else $error("Done not a pulse."); // [R25]
	property p_done_loads;
		@(posedge clk_in) disable iff (!rst_b_in)
		finish |=> (done_pulse && result_value == $past(resolved));
	endproperty
	a_done_loads: assert property (p_done_loads) else $error("Result not loaded."); // [R3]
	property p_write_aborts;
		@(posedge clk_in) disable iff (!rst_b_in)
		reg_write |=> (state == SAC_IDLE && !done_pulse);
	endproperty
	a_write_aborts: assert property (p_write_aborts) else $error("Write did not abort."); // [R21]
	property p_chan_upper_zero;
		@(posedge clk_in) disable iff (!rst_b_in) channel_select_reg[7:3] == 5'd0;
	endproperty
	a_chan_upper_zero: assert property (p_chan_upper_zero) else $error("Channel bits set."); // [R16]
	property p_hw_stops;
		@(posedge clk_in) disable iff (!rst_b_in) (finish && hw_mode) |=> state == SAC_IDLE;
	endproperty
	a_hw_stops: assert property (p_hw_stops) else $error("Hardware mode kept running."); // [R4]
	property p_sw_repeats;
		@(posedge clk_in) disable iff (!rst_b_in) (finish && !hw_mode) |=> state == SAC_SAMPLE;
	endproperty
	a_sw_repeats: assert property (p_sw_repeats) else $error("Software mode stopped."); // [R5]
	property p_off_idle;
		@(posedge clk_in) disable iff (!rst_b_in)
		(!enable && state == SAC_IDLE) |=> state == SAC_IDLE;
	endproperty
	a_off_idle: assert property (p_off_idle) else $error("Started while disabled."); // [R6]
	property p_cold_flag;
		@(posedge clk_in) disable iff (!rst_b_in) (enable && !ref_was_on) |=> result_undefined;
	endproperty
	a_cold_flag: assert property (p_cold_flag) else $error("Cold start not flagged."); // [R11]
endmodule

// [tb/sac_analog_model.sv]
// Analog side model: one fixed level per input channel and an ideal comparator.
`timescale 1ns/10ps
module sac_analog_model
(
	// Converter side.
	input  wire logic [7:0]            select_in,
	input  wire sac_pkg::sac_byte_type trial_in,
	// Comparator answer.
	output logic                       comparator_out
);
	import sac_pkg::*;
	sac_byte_type level; // Voltage of the selected input, in result codes.
	// Each channel sits at its own level, so a wrong select shows up in the result.
	always_comb
	begin
		level = 8'h00;
		for (int n = 0; n < 8; n++)
			if (select_in[n])
				level = 8'h1d + 8'h21 * n[7:0];
	end
	// The answer is 1 when the input is at or above the tap.
	// It settles at once, so even the short codes of this clock resolve; real parts need more.
	assign comparator_out = (level >= trial_in);
endmodule

// [tb/test_sac_control.sv]
// Self-checking bench of the converter control: registers, timing, aborts and triggers.
`timescale 1ns/10ps
module test_sac_control;
	import sac_pkg::*;
	logic         clk_in;
	logic         rst_b_in;
	logic [15:0]  addr_in;
	logic         wr_in;
	sac_byte_type wr_mask_in;
	sac_byte_type wr_data_in;
	logic         rd_in;
	sac_byte_type rd_data_out;
	logic         comparator;
	logic         ext_trigger_pin_in;
	logic [7:0]   analog_select_out;
	sac_byte_type trial_value_out;
	logic         reference_enable_out;
	logic         conversion_busy_out;
	logic         conversion_done_irq_out;
	int           miscompares;
	int           samples_checked;
	int           dones = 0;   // Done pulses seen so far.
	sac_byte_type rd;          // Last value read back.
	int           c;           // Cycles counted by the last wait.
	int           d0;          // Done count at the start of a window.
	////////////////////////////////////////////////////////////////////////////////
	sac_control dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
		.wr_in(wr_in), .wr_mask_in(wr_mask_in), .wr_data_in(wr_data_in), .rd_in(rd_in),
		.rd_data_out(rd_data_out), .comparator_in(comparator),
		.ext_trigger_pin_in(ext_trigger_pin_in), .analog_select_out(analog_select_out),
		.trial_value_out(trial_value_out), .reference_enable_out(reference_enable_out),
		.conversion_busy_out(conversion_busy_out),
		.conversion_done_irq_out(conversion_done_irq_out));
	sac_analog_model model_u (.select_in(analog_select_out), .trial_in(trial_value_out),
		.comparator_out(comparator));
	// Free-running 25 MHz clock.
	initial
	begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	// Done is a one-cycle pulse, so it is counted at every edge.
	always @(posedge clk_in)
		if (conversion_done_irq_out === 1'b1)
			dones <= dones + 1;
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
		samples_checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// One write: strobe high for a single edge, then a low edge before the next one.
	task automatic reg_wr(input logic [15:0] a, input sac_byte_type m, input sac_byte_type d);
		@(posedge clk_in);
		addr_in <= a;
		wr_mask_in <= m;
		wr_data_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	// Only the converter's registers and one unmapped address are read, never the port that shares its pins.
	// Read data is registered, so it is taken just after the edge that saw the strobe.
	task automatic reg_rd(input logic [15:0] a);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 rd = rd_data_out;
	endtask
	// Bounded wait for the next done pulse; a hang ends the run.
	task automatic wait_done();
		c = 0;
		do
		begin
			@(posedge clk_in);
			#1 c++;
		end while (conversion_done_irq_out !== 1'b1 && c < 1000);
		if (c >= 1000)
		begin
			check("done pulse", 16'h0001, 16'h0000);
			finish_test();
		end
	endtask
	// Level that the analog model holds on each channel.
	function automatic sac_byte_type level(input int ch);
		return 8'h1d + 8'h21 * ch[7:0];
	endfunction
	// Conversion length of each time code; prohibited codes behave as the longest.
	function automatic int len(input int code);
		case (code)
			0: return 144;
			1: return 120;
			2: return 96;
			5: return 240;
			6: return 192;
			default: return 288;
		endcase
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	task automatic test_reset();
		reg_rd(16'hff80);
		check("mode reset", 16'h0000, {8'h00, rd});
		reg_rd(16'hff81);
		check("channel reset", 16'h0000, {8'h00, rd});
		reg_rd(16'hff90);
		check("unmapped read", 16'h0000, {8'h00, rd});
		check("reference off", 16'h0000, {15'h0000, reference_enable_out});
		$display("test reset finished");
	endtask
	task automatic test_regs();
		reg_wr(16'hff81, 8'hff, 8'hff);
		reg_rd(16'hff81);
		check("channel upper bits", 16'h0007, {8'h00, rd});
		check("one-hot select", 16'h0080, {8'h00, analog_select_out});
		// Enabling with the reference off is a cold start; the reference follows the enable.
		reg_wr(16'hff80, 8'hff, 8'h80);
		repeat (2) @(posedge clk_in);
		#1 check("reference by enable", 16'h0001, {15'h0000, reference_enable_out});
		reg_wr(16'hff80, 8'hff, 8'h00);
		reg_wr(16'hff80, 8'h01, 8'hff);
		reg_rd(16'hff80);
		check("bit write", 16'h0001, {8'h00, rd});
		check("reference bit", 16'h0001, {15'h0000, reference_enable_out});
		reg_wr(16'hff80, 8'h02, 8'h02);
		reg_rd(16'hff80);
		check("edge low bit", 16'h0003, {8'h00, rd});
		reg_wr(16'hff80, 8'hff, 8'h00);
		repeat (2) @(posedge clk_in);
		#1 check("reference stopped", 16'h0000, {15'h0000, reference_enable_out});
		$display("test regs finished");
	endtask
	// Reference settles before enabling, so every result is valid.
	task automatic test_convert();
		reg_wr(16'hff80, 8'hff, 8'h01);
		repeat (350) @(posedge clk_in);
		reg_wr(16'hff80, 8'hff, 8'h81);
		for (int ch = 0; ch < 8; ch++)
		begin
			reg_wr(16'hff81, 8'hff, ch[7:0]);
			wait_done();
			reg_rd(16'hff82);
			check("result", {8'h00, level(ch)}, {8'h00, rd});
			check("select", 16'h0001 << ch, {8'h00, analog_select_out});
		end
		$display("test convert finished");
	endtask
	// Period between repeated results follows the time code, split into nine steps.
	task automatic test_timing();
		for (int code = 0; code < 8; code++)
		begin
			reg_wr(16'hff80, 8'hff, 8'h01);
			reg_wr(16'hff80, 8'hff, 8'h81 | (code[7:0] << 3));
			wait_done();
			wait_done();
			check("period", len(code) / 9 * 9, c);
		end
		$display("test timing finished");
	endtask
	task automatic test_abort();
		reg_wr(16'hff80, 8'hff, 8'h81);
		wait_done();
		repeat (60) @(posedge clk_in);
		reg_wr(16'hff81, 8'hff, 8'h02);
		wait_done();
		// A restart runs a whole conversion again, so the wait spans at least one length.
		check("restart length", 16'h0001, {15'h0000, c >= len(0) / 9 * 9});
		reg_rd(16'hff82);
		check("restart result", {8'h00, level(2)}, {8'h00, rd});
		repeat (60) @(posedge clk_in);
		#1 check("running busy", 16'h0001, {15'h0000, conversion_busy_out});
		reg_wr(16'hff80, 8'hff, 8'h01);
		d0 = dones;
		repeat (300) @(posedge clk_in);
		check("stopped dones", 16'h0000, dones - d0);
		check("stopped busy", 16'h0000, {15'h0000, conversion_busy_out});
		$display("test abort finished");
	endtask
	// Every edge code is tried with one falling and one rising edge of the pin.
	task automatic test_hw();
		for (int e = 0; e < 4; e++)
		begin
			reg_wr(16'hff80, 8'hff, 8'hc1 | (e[7:0] << 1));
			d0 = dones;
			repeat (300) @(posedge clk_in);
			check("steady pin", 16'h0000, dones - d0);
			ext_trigger_pin_in <= 1'b0;
			repeat (400) @(posedge clk_in);
			check("falling edge", e & 1, dones - d0);
			d0 = dones;
			ext_trigger_pin_in <= 1'b1;
			repeat (400) @(posedge clk_in);
			check("rising edge", e >> 1, dones - d0);
		end
		$display("test hw finished");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		rst_b_in = 1'b0;
		addr_in = 16'h0000;
		wr_in = 1'b0;
		wr_mask_in = 8'h00;
		wr_data_in = 8'h00;
		rd_in = 1'b0;
		ext_trigger_pin_in = 1'b1;
		miscompares = 0;
		samples_checked = 0;
		repeat (20) @(posedge clk_in);
		rst_b_in <= 1'b1;
		test_reset();
		test_regs();
		test_convert();
		test_timing();
		test_abort();
		test_hw();
		finish_test();
	end
endmodule
